// >>> core/vfc_pkg.sv
// Behaviour
// - odd wanted during even: skip even and odd, lock on even, take odd.
// - odd wanted during odd: skip partial odd, lock on even, take next odd.
// - stop aborts capture at once, cancelling any transfer in progress.
// - after single shot, stay locked ignoring starts until a stop.
// - readable 4-bit capture status, values 0 to 15.
// - bit 0 toggles per stored even field, bit 1 per stored odd field.
// - bits 2 and 3 set on even/odd field captured, held until new start.
// - separate fields: even at base, odd at base plus even field size.
// - only one field type enabled, without interleave: that field is written at base.
// - interleave: both fields form one frame at base, lines interleaved.
// - end-of-field event raised per captured field, only while started.
// - end-of-field indication holds until host clears it.
// - xor of toggle flags gives parity of the stored field count, 1 odd.
// - 2-bit signal status: 0 none, 1 undefined, 2 present, 3 locked.
// - no video declared after 31 line periods without sync.
// - line lock after 32 good lines, dropped after 32 bad lines.
// - 8-bit captured-field counter wrapping 255 to 0.
// - counter clear command sets the field counter to zero.
// - even wanted during even: skip partial even and odd, take next even.
// - single shot takes one image per start.
// - continuous field mode alternates the two field regions.
`default_nettype none
package vfc_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_CMD     = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_SIGNAL  = 8'h0C;
	localparam logic [7:0] ADDR_COUNT   = 8'h10;
	localparam logic [7:0] ADDR_BASE    = 8'h14;
	localparam logic [7:0] ADDR_ESIZE   = 8'h18;
	localparam logic [7:0] ADDR_OSIZE   = 8'h1C;
	localparam logic [7:0] ADDR_LINELEN = 8'h20;
	localparam logic [7:0] ADDR_WADDR   = 8'h24;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_INTERLEAVE = 0;
	localparam int CTRL_ONESHOT    = 1;
	localparam int CTRL_IRQ_EN     = 2;
	localparam int CTRL_WANT_EVEN  = 3;
	localparam int CTRL_WANT_ODD   = 4;
	localparam int CMD_START       = 0;
	localparam int CMD_STOP        = 1;
	localparam int CMD_CNT_CLR     = 2;
	localparam int CMD_EVT_CLR     = 3;
	localparam int STAT_EVENT      = 4;
	localparam int STAT_ACTIVE     = 5;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [4:0]  CTRL_RESET       = 5'h18;
	localparam logic [31:0] READ_ZERO        = 32'h00000000;
	localparam logic [4:0]  NOSYNC_LINES     = 5'h1F;
	localparam logic [5:0]  LOCK_LINES       = 6'h20;
	localparam logic [15:0] LINE_TOL         = 16'h0001;
	localparam int          CLK_MHZ          = 125;
	localparam int          LINE_NS          = 64000;
	localparam int          LINE_CYCLES      = (LINE_NS * CLK_MHZ) / 1000;
	localparam logic [1:0]  SIG_NONE         = 2'h0;
	localparam logic [1:0]  SIG_PRESENT      = 2'h2;
	localparam logic [1:0]  SIG_LOCKED       = 2'h3;

	typedef enum { ST_IDLE, ST_SYNC, ST_WAIT_EVEN, ST_CAPTURE, ST_HOLD } vfc_state_type;

	// decoded video timing from the front end
	typedef struct packed {
		logic field_start;
		logic field_odd;
		logic field_end;
		logic hsync;
		logic pixel_valid;
	} vfc_video_type;

	// pixel write toward host memory
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} vfc_write_type;
endpackage : vfc_pkg
`default_nettype wire

// >>> core/vfc_capture.sv
// The APB interface to the registers and the address map were left to the implementer.
`default_nettype none
module vfc_capture
	import vfc_pkg::*;
(
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// video stream
	input  wire vfc_video_type video,
	input  wire logic [1:0]    pixel_bytes,
	// memory writes
	output vfc_write_type      mem_wr,
	output logic               field_end_irq
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire           acc       = psel & penable & ~pready;
	// writes and commands commit at the edge that completes the transfer
	wire           wr        = psel & penable & pready & pwrite;
	wire           hit_ctrl  = paddr == ADDR_CTRL;
	wire           hit_cmd   = paddr == ADDR_CMD;
	wire           hit_base  = paddr == ADDR_BASE;
	wire           hit_esz   = paddr == ADDR_ESIZE;
	wire           hit_osz   = paddr == ADDR_OSIZE;
	wire           hit_ll    = paddr == ADDR_LINELEN;
	wire           mapped    = hit_ctrl | hit_cmd | hit_base | hit_esz | hit_osz | hit_ll
	                           | paddr == ADDR_STATUS | paddr == ADDR_SIGNAL | paddr == ADDR_COUNT
	                           | paddr == ADDR_WADDR;
	wire           cmd_start = wr & hit_cmd & pwdata[CMD_START];
	wire           cmd_stop  = wr & hit_cmd & pwdata[CMD_STOP];
	wire           field_count_clear = wr & hit_cmd & pwdata[CMD_CNT_CLR];
	wire           cmd_eclr  = wr & hit_cmd & pwdata[CMD_EVT_CLR];

	logic [4:0]    ctrl;
	logic [31:0]   base;
	logic [31:0]   even_size;
	logic [31:0]   odd_size;
	logic [15:0]   line_len;
	vfc_state_type state;
	logic [3:0]    status;
	logic          field_event;
	logic [7:0]    field_count;
	logic [1:0]    sig_status;
	logic          got_even_arm;
	logic          got_even;
	logic [31:0]   ptr_even;
	logic [31:0]   ptr_odd;
	logic [15:0]   line_pos;
	logic [15:0]   hs_pos;
	logic [4:0]    nosync_cnt;
	logic [5:0]    good_run;
	logic [5:0]    bad_run;
	logic          line_lock;
	logic [31:0]   since_hs;

	wire interleave_fields    = ctrl[CTRL_INTERLEAVE];
	wire one_capture_only     = ctrl[CTRL_ONESHOT];
	wire field_end_irq_enable = ctrl[CTRL_IRQ_EN];
	wire want_even   = ctrl[CTRL_WANT_EVEN] & (even_size != READ_ZERO);
	wire want_odd    = ctrl[CTRL_WANT_ODD] & (odd_size != READ_ZERO);

	// ----------------------------------------
	// capture sequencing
	// ----------------------------------------
	wire fs       = video.field_start;
	wire fe       = video.field_end;
	wire odd      = video.field_odd;
	wire this_ok  = odd ? want_odd : want_even;
	// a capture that starts with odd still waits for a whole even field first
	wire start_ok = fs & (odd ? (want_odd & ~want_even & got_even) : want_even);
	wire done_img = fe & state == ST_CAPTURE & this_ok
	                & (odd ? 1'b1 : ~want_odd);
	wire store    = state == ST_CAPTURE & video.pixel_valid & this_ok;
	wire [31:0] field_count_read = {24'h000000, field_count};

	vfc_state_type next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (cmd_start) next_state = ST_SYNC;
			end
			ST_SYNC: begin
				// the field in flight is partial; wait for a boundary
				if (fs & want_odd & want_even & ~odd) next_state = ST_CAPTURE;
				else if (start_ok) next_state = ST_CAPTURE;
			end
			ST_WAIT_EVEN: next_state = ST_CAPTURE;
			ST_CAPTURE: begin
				if (done_img & one_capture_only) next_state = ST_HOLD;
			end
			ST_HOLD: next_state = ST_HOLD;
		endcase
		if (cmd_stop) next_state = ST_IDLE;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state    <= ST_IDLE;
			got_even <= 1'b0;
		end else begin
			state    <= next_state;
			// held until leaving sync, so a gap between field end and start is harmless
			got_even <= state == ST_SYNC & (got_even | fe & ~odd & got_even_arm);
		end
	end

	// an even field only counts as a sync point if seen from its start
	always_ff @(posedge mclk) begin
		if (rst | state != ST_SYNC) got_even_arm <= 1'b0;
		else if (fs) got_even_arm <= ~odd;
	end

	// ----------------------------------------
	// memory placement
	// ----------------------------------------
	wire [31:0] odd_base  = interleave_fields ? base + {16'h0000, line_len}
	                        : (want_even ? base + even_size : base);
	wire [31:0] next_ptr  = (odd ? ptr_odd : ptr_even) + {30'h00000000, pixel_bytes};
	wire        line_done = interleave_fields & line_pos + {14'h0000, pixel_bytes} >= line_len;

	always_ff @(posedge mclk) begin
		if (rst) begin
			ptr_even <= 32'h00000000;
			ptr_odd  <= 32'h00000000;
			line_pos <= 16'h0000;
			mem_wr   <= '0;
		end else begin
			mem_wr.valid <= store & ~cmd_stop;
			mem_wr.addr  <= odd ? ptr_odd : ptr_even;
			if (fs | state == ST_SYNC) begin
				ptr_even <= base;
				ptr_odd  <= odd_base;
				line_pos <= 16'h0000;
			end else if (store) begin
				// interleaved lines skip over the other field's line
				if (line_done) begin
					line_pos <= 16'h0000;
					if (odd) ptr_odd <= next_ptr + {16'h0000, line_len};
					else ptr_even <= next_ptr + {16'h0000, line_len};
				end else begin
					line_pos <= line_pos + {14'h0000, pixel_bytes};
					if (odd) ptr_odd <= next_ptr;
					else ptr_even <= next_ptr;
				end
			end
		end
	end

	// ----------------------------------------
	// status, event and counter
	// ----------------------------------------
	wire captured = fe & state == ST_CAPTURE & this_ok & ~cmd_stop;
	always_ff @(posedge mclk) begin
		if (rst) begin
			status      <= 4'h0;
			field_event <= 1'b0;
			field_count <= 8'h00;
		end else begin
			if (cmd_start & state == ST_IDLE) status[3:2] <= 2'h0;
			if (captured) begin
				status[odd]     <= ~status[odd];
				status[2 + odd] <= 1'b1;
			end
			// set beats clear in the same cycle
			if (captured & field_end_irq_enable) field_event <= 1'b1;
			else if (cmd_eclr) field_event <= 1'b0;
			if (field_count_clear) field_count <= 8'h00;
			else if (captured) field_count <= field_count + 8'h01;
		end
	end

	// ----------------------------------------
	// signal presence and line lock
	// ----------------------------------------
	logic hs_q;
	wire  hs_rise = video.hsync & ~hs_q;
	wire [15:0] dev = hs_pos > line_len ? hs_pos - line_len : line_len - hs_pos;
	wire  good_line = dev <= LINE_TOL;
	wire  line_tick = since_hs >= LINE_CYCLES[31:0];
	always_ff @(posedge mclk) begin
		if (rst) begin
			hs_q       <= 1'b0;
			hs_pos     <= 16'h0000;
			nosync_cnt <= NOSYNC_LINES;
			good_run   <= 6'h00;
			bad_run    <= 6'h00;
			line_lock  <= 1'b0;
			since_hs   <= 32'h00000000;
			sig_status <= SIG_NONE;
		end else begin
			hs_q <= video.hsync;
			if (hs_rise) begin
				hs_pos     <= 16'h0000;
				since_hs   <= 32'h00000000;
				nosync_cnt <= 5'h00;
				good_run   <= good_line ? (good_run == LOCK_LINES ? good_run : good_run + 6'h01) : 6'h00;
				bad_run    <= good_line ? 6'h00 : (bad_run == LOCK_LINES ? bad_run : bad_run + 6'h01);
			end else begin
				hs_pos <= hs_pos + 16'h0001;
				if (line_tick) begin
					since_hs <= 32'h00000000;
					if (nosync_cnt != NOSYNC_LINES) nosync_cnt <= nosync_cnt + 5'h01;
				end else since_hs <= since_hs + 32'h00000001;
			end
			if (good_run == LOCK_LINES) line_lock <= 1'b1;
			else if (bad_run == LOCK_LINES) line_lock <= 1'b0;
			sig_status <= nosync_cnt == NOSYNC_LINES ? SIG_NONE
			              : (line_lock ? SIG_LOCKED : SIG_PRESENT);
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	wire [31:0] rd_mux =
		hit_ctrl              ? {27'h0000000, ctrl} :
		paddr == ADDR_STATUS  ? {26'h0000000, state != ST_IDLE, field_event, status} :
		paddr == ADDR_SIGNAL  ? {30'h00000000, sig_status} :
		paddr == ADDR_COUNT   ? field_count_read :
		hit_base              ? base :
		hit_esz               ? even_size :
		hit_osz               ? odd_size :
		hit_ll                ? {16'h0000, line_len} :
		paddr == ADDR_WADDR   ? mem_wr.addr : READ_ZERO;

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl          <= CTRL_RESET;
			base          <= 32'h00000000;
			even_size     <= 32'h00000000;
			odd_size      <= 32'h00000000;
			line_len      <= 16'h0000;
			prdata        <= 32'h00000000;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			field_end_irq <= 1'b0;
		end else begin
			// one wait state keeps read data registered
			pready  <= acc;
			pslverr <= acc & ~mapped;
			prdata  <= acc & ~pwrite ? rd_mux : 32'h00000000;
			if (wr & hit_ctrl) ctrl <= pwdata[4:0];
			if (wr & hit_base) base <= pwdata;
			if (wr & hit_esz) even_size <= pwdata;
			if (wr & hit_osz) odd_size <= pwdata;
			if (wr & hit_ll) line_len <= pwdata[15:0];
			field_end_irq <= field_event;
		end
	end

endmodule : vfc_capture
`default_nettype wire

// >>> test/vfc_capture_sva.sv
`default_nettype none
module vfc_capture_sva
	import vfc_pkg::*;
(
	// clock, reset and apb
	input wire logic          mclk,
	input wire logic          rst,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [7:0]    paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	// video and memory side
	input wire vfc_video_type video,
	input wire logic [1:0]    pixel_bytes,
	input wire vfc_write_type mem_wr,
	input wire logic          field_end_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----
	// host write decode
	// ----
	// ctrl writes excluded too, though the enable only gates setting the event, not the held irq
	wire logic host_wr = psel && pwrite && (paddr == ADDR_CMD || paddr == ADDR_CTRL);
	wire logic stop_wr = psel && penable && pready && pwrite && paddr == ADDR_CMD && pwdata[CMD_STOP];
	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held beyond one cycle");
	decode_err_a: assert property (psel && penable && pready |-> pslverr == (paddr > ADDR_WADDR || paddr[1:0] != 2'h0))
		else $error("pslverr does not match address decode");
	err_pair_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	read_idle_a: assert property (!pready |-> prdata == READ_ZERO)
		else $error("read data not zero outside answer");
	event_hold_a: assert property (field_end_irq && !host_wr && !$past(host_wr) |=> field_end_irq)
		else $error("end of field indication dropped without clear");
	event_cause_a: assert property ($rose(field_end_irq) |-> $past(video.field_end, 2))
		else $error("end of field indication without field end");
	stop_quiet_a: assert property (stop_wr |=> !mem_wr.valid [*4])
		else $error("memory write after stop");
	reset_idle_a: assert property ($fell(rst) |-> !field_end_irq && !mem_wr.valid && !pready)
		else $error("outputs not idle after reset");
endmodule : vfc_capture_sva
bind vfc_capture vfc_capture_sva vfc_capture_sva_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .video, .pixel_bytes, .mem_wr, .field_end_irq);
`default_nettype wire

// >>> test/vfc_video_src.sv
`default_nettype none
module vfc_video_src
	import vfc_pkg::*;
#(
	parameter int LINES = 4,
	parameter int LEN   = 16
)
(
	// clock and reset
	input  wire logic    mclk,
	input  wire logic    rst,
	// stream
	input  wire logic    on,
	output var vfc_video_type video
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cyc;
	logic [7:0] line;
	logic       odd;
	wire logic  last_c = cyc == 8'(LEN - 1);
	wire logic  last_l = line == 8'(LINES - 1);
	always_ff @(posedge mclk) begin
		if (rst || !on) begin
			cyc  <= 8'h00;
			line <= 8'h00;
			odd  <= 1'b0;
		end else begin
			cyc  <= last_c ? 8'h00 : cyc + 8'h01;
			line <= last_c ? (last_l ? 8'h00 : line + 8'h01) : line;
			odd  <= (last_c && last_l) ? !odd : odd;
		end
	end
	// silent when off: no sync, so the lines stay at their idle low
	assign video = {on && cyc == 8'h00 && line == 8'h00, odd, on && last_c && last_l, on && cyc < 8'h02,
		on && cyc >= 8'h04 && cyc < 8'h08};
endmodule : vfc_video_src
`default_nettype wire

// >>> test/tb_top.sv
`default_nettype none
module tb_top
	import vfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          mclk, rst, psel, penable, pwrite, pready, pslverr, field_end_irq, vid_on;
	logic [7:0]    paddr, cnt;
	logic [31:0]   pwdata, prdata, q, n_end;
	logic [31:0]   fa [2];
	logic [1:0]    seen;
	logic          te, to, e_last;
	vfc_video_type video;
	vfc_write_type mem_wr;
	int            err_count, n_tests, i, k;
	// cases: ctrl, sizes {odd,even}, parity at start, fields passed before done
	localparam logic [4:0]  T_CTRL [4] = '{5'h16, 5'h16, 5'h0E, 5'h1E};
	localparam logic [1:0]  T_SIZE [4] = '{2'h2, 2'h2, 2'h1, 2'h3};
	localparam logic        T_PAR [4]  = '{1'b0, 1'b1, 1'b0, 1'b1};
	localparam logic [31:0] T_ENDS [4] = '{32'h4, 32'h3, 32'h3, 32'h3};
	vfc_capture vfc_capture_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .video(video),
		.pixel_bytes(2'h1), .mem_wr(mem_wr), .field_end_irq(field_end_irq));
	vfc_video_src vfc_video_src_i (.mclk(mclk), .rst(rst), .on(vid_on), .video(video));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (video.field_end) n_end <= n_end + 32'h1;
		if (mem_wr.valid && !seen[video.field_odd]) begin
			seen[video.field_odd] <= 1'b1;
			fa[video.field_odd] <= mem_wr.addr;
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge mclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, q, e_last);
		chk(nm, exp, q);
	endtask : rdc
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, vid_on, te, to, cnt, n_end, seen, e_last} = '0;
		rst = 1'b1;
		err_count = 0;
		n_tests = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rdc("ctrl", ADDR_CTRL, {27'h0, CTRL_RESET});
		rdc("status", ADDR_STATUS, 32'h0);
		rdc("count", ADDR_COUNT, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, e_last});
		wr(ADDR_BASE, 32'h1000);
		wr(ADDR_LINELEN, 32'h10);
		vid_on <= 1'b1;
		repeat (640) @(posedge mclk);
		rdc("locked", ADDR_SIGNAL, {30'h0, SIG_LOCKED});
		for (i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, {27'h0, T_CTRL[i]});
			wr(ADDR_ESIZE, T_SIZE[i][0] ? 32'h10 : 32'h0);
			wr(ADDR_OSIZE, T_SIZE[i][1] ? 32'h10 : 32'h0);
			do @(posedge mclk); while (!(video.field_start && video.field_odd == T_PAR[i]));
			seen <= 2'h0;
			n_end <= 32'h0;
			wr(ADDR_CMD, 32'h1);
			k = 0;
			do begin
				repeat (4) @(posedge mclk);
				apb(1'b0, ADDR_STATUS, 32'h0, q, e_last);
				k++;
			end while ((q[3:2] & T_SIZE[i]) != T_SIZE[i] && k < 200);
			chk("fields passed", T_ENDS[i], n_end);
			te ^= T_SIZE[i][0];
			to ^= T_SIZE[i][1];
			chk("status", {27'h0, 1'b1, T_SIZE[i], to, te}, q & 32'h1F);
			chk("irq", 32'h1, {31'h0, field_end_irq});
			if (T_SIZE[i][0]) chk("even addr", 32'h1000, fa[0]);
			if (T_SIZE[i][1]) chk("odd addr", T_SIZE[i][0] ? 32'h1010 : 32'h1000, fa[1]);
			cnt += 8'(T_SIZE[i][0]) + 8'(T_SIZE[i][1]);
			wr(ADDR_CMD, 32'h1);
			repeat (200) @(posedge mclk);
			rdc("count held", ADDR_COUNT, {24'h0, cnt});
			wr(ADDR_CMD, 32'hA);
			repeat (3) @(posedge mclk);
			chk("irq clear", 32'h0, {31'h0, field_end_irq});
		end
		wr(ADDR_CMD, 32'h4);
		rdc("count clear", ADDR_COUNT, 32'h0);
		// a large even size tells the interleaved odd base from the separate one
		wr(ADDR_ESIZE, 32'h40);
		wr(ADDR_CTRL, 32'h1D);
		seen <= 2'h0;
		wr(ADDR_CMD, 32'h1);
		n_end <= 32'h0;
		do @(posedge mclk); while (n_end != 32'h3);
		wr(ADDR_CMD, 32'h4);
		n_end <= 32'h0;
		do @(posedge mclk); while (n_end != 32'd257);
		rdc("count wrap", ADDR_COUNT, 32'h1);
		chk("frame even addr", 32'h1000, fa[0]);
		chk("frame odd addr", 32'h1010, fa[1]);
		do @(posedge mclk); while (!mem_wr.valid);
		wr(ADDR_CMD, 32'hA);
		wr(ADDR_LINELEN, 32'h28);
		repeat (640) @(posedge mclk);
		rdc("lock lost", ADDR_SIGNAL, {30'h0, SIG_PRESENT});
		close_out();
	end
endmodule : tb_top
`default_nettype wire
